// ===== bench/qst_queue_model.sv
`timescale 1ns/1ns
module qst_queue_model (
	// clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              rst_i,
	// queue side
	input  wire qst_pkg::qst_evt_t submit_i,
	input  wire logic              hold_i,
	output logic [7:0]             done_o
);
	logic [7:0] busy;
	// held entries never complete, so only software can free them
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy <= 8'h0;
			done_o <= 8'h0;
		end else begin
			busy <= (submit_i.valid && !hold_i) ? 8'h1 << submit_i.chan : 8'h0;
			done_o <= busy;
		end
	end
endmodule

// ===== bench/qst_tracker_asserts.sv
`timescale 1ns/1ns
module qst_tracker_asserts #(
	parameter int NCH = 8
) (
	input wire logic               ref_clk_i,
	input wire logic               rst_i,
	input wire logic               s_axi_arvalid,
	input wire logic               s_axi_arready,
	input wire logic [31:0]        s_axi_rdata,
	input wire logic               s_axi_rvalid,
	input wire logic               s_axi_rready,
	input wire logic               s_axi_bvalid,
	input wire logic               s_axi_bready,
	input wire logic               queue_ready_i,
	input wire qst_pkg::qst_evt_t  submit_o,
	input wire qst_pkg::qst_chan_t status_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	AST_UPPER_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	AST_SET_AFTER_SUBMIT: assert property (submit_o.valid |=> status_o[$past(submit_o.chan)])
		else $error("status not set after submit");
	AST_RISE_CAUSE: assert property ((status_o & ~$past(status_o)) != 8'h0 |->
		$past(submit_o.valid) && (status_o & ~$past(status_o)) == 8'h1 << $past(submit_o.chan))
		else $error("status set without submit");
	AST_NO_REPRIORITISE: assert property (submit_o.valid |-> !status_o[submit_o.chan])
		else $error("queued channel submitted again");
	AST_SUBMIT_READY: assert property (submit_o.valid |-> $past(queue_ready_i) || $past(queue_ready_i, 2))
		else $error("submit while queue not ready");
	AST_RVALID_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_RVALID_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	AST_BVALID_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	cover property (submit_o.valid);
	cover property (status_o == 8'hFF);
	cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind qst_tracker qst_tracker_asserts #(.NCH(NCH)) u_chk (.ref_clk_i, .rst_i, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
	.queue_ready_i, .submit_o, .status_o);

// ===== bench/qst_tracker_test.sv
`timescale 1ns/1ns
`include "qst_defs.svh"
module qst_tracker_test;
	logic ref_clk_i = 1'h0, rst_i = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
	logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ord_clear_i = 1'h0;
	logic queue_ready_i = 1'h0, hold = 1'h1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [7:0] evt_i = 8'h0, ord_status_i = 8'h0, ord_clear_mask_i = 8'h0;
	logic [7:0] hw_done_i, ord_status_o, latch_o;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	qst_pkg::qst_evt_t submit_o;
	qst_pkg::qst_chan_t status_o;
	int mismatches = 0, total_checks = 0;
	always #50 ref_clk_i = ~ref_clk_i;
	qst_tracker #(.NCH(8)) dut (.ref_clk_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .evt_i, .queue_ready_i, .hw_done_i, .ord_status_i,
		.ord_clear_i, .ord_clear_mask_i, .submit_o, .status_o, .ord_status_o, .latch_o);
	qst_queue_model model (.ref_clk_i, .rst_i, .submit_i(submit_o), .hold_i(hold), .done_o(hw_done_i));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge ref_clk_i);
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		chk("bresp", 32'(`QST_RESP_OKAY), 32'(s_axi_bresp));
		s_axi_bready <= 1'h0;
	endtask
	// data is only compared on an OKAY answer
	task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge ref_clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge ref_clk_i);
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		chk("rresp", 32'(er), 32'(s_axi_rresp));
		if (er == `QST_RESP_OKAY) chk("rdata", e, s_axi_rdata);
		s_axi_rready <= 1'h0;
	endtask
	task automatic ev(input logic [7:0] m);
		@(posedge ref_clk_i);
		evt_i <= m;
		@(posedge ref_clk_i);
		evt_i <= 8'h0;
		repeat (12) @(posedge ref_clk_i);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge ref_clk_i);
		mismatches++;
		tally_and_finish();
	end
	initial begin
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'h0;
		rchk(`QST_OFF_STATUS, 32'(`QST_RST_STATUS), `QST_RESP_OKAY);
		rchk(`QST_OFF_CLEAR, 32'h0, `QST_RESP_OKAY);
		rchk(12'h020, 32'h0, `QST_RESP_SLVERR);
		ev(8'h04);
		chk("latch", 32'h0, 32'(latch_o));
		wr(`QST_OFF_EN_SET, 32'hFF);
		rchk(`QST_OFF_ENABLE, 32'hFF, `QST_RESP_OKAY);
		ev(8'hFF);
		chk("latch", 32'hFF, 32'(latch_o));
		queue_ready_i <= 1'h1;
		repeat (40) @(posedge ref_clk_i);
		rchk(`QST_OFF_STATUS, 32'hFF, `QST_RESP_OKAY);
		ev(8'h08);
		chk("latch", 32'h08, 32'(latch_o));
		rchk(`QST_OFF_LATCH, 32'h08, `QST_RESP_OKAY);
		ord_status_i <= 8'hA5;
		@(posedge ref_clk_i);
		ord_status_i <= 8'h0;
		ord_clear_i <= 1'h1;
		ord_clear_mask_i <= 8'h05;
		@(posedge ref_clk_i);
		ord_clear_i <= 1'h0;
		repeat (4) @(posedge ref_clk_i);
		chk("ord_status", 32'hA0, 32'(ord_status_o));
		chk("latch", 32'h08, 32'(latch_o));
		wr(`QST_OFF_CLEAR, 32'h0);
		repeat (4) @(posedge ref_clk_i);
		chk("status", 32'hFF, 32'(status_o));
		chk("latch", 32'h08, 32'(latch_o));
		wr(`QST_OFF_CLEAR, 32'h0C);
		repeat (4) @(posedge ref_clk_i);
		chk("status", 32'hF3, 32'(status_o));
		chk("latch", 32'h0, 32'(latch_o));
		hold <= 1'h0;
		ev(8'h04);
		chk("latch", 32'h0, 32'(latch_o));
		rchk(`QST_OFF_STATUS, 32'hF3, `QST_RESP_OKAY);
		queue_ready_i <= 1'h0;
		hold <= 1'h1;
		ev(8'h04);
		// open the queue one edge before the address is taken, so grant and clear coincide
		fork
			wr(`QST_OFF_CLEAR, 32'h04);
			begin
				@(posedge ref_clk_i);
				while (s_axi_awready === 1'h1) @(posedge ref_clk_i);
				queue_ready_i <= 1'h1;
			end
		join
		repeat (4) @(posedge ref_clk_i);
		chk("status", 32'hF7, 32'(status_o));
		chk("latch", 32'h0, 32'(latch_o));
		wr(`QST_OFF_EN_CLR, 32'h01);
		rchk(`QST_OFF_ENABLE, 32'hFE, `QST_RESP_OKAY);
		ev(8'h01);
		chk("latch", 32'h0, 32'(latch_o));
		tally_and_finish();
	end
endmodule

// ===== core/qst_arbiter.sv
`timescale 1ns/1ns
module qst_arbiter #(
	parameter int NCH = 8
) (
	// clock and reset
	input  wire logic           ref_clk_i,
	input  wire logic           rst_i,
	// candidates
	input  wire logic [NCH-1:0] pend_i,
	input  wire logic [NCH-1:0] busy_i,
	input  wire logic           take_ok_i,
	// grant
	output logic                grant_vld_o,
	output logic [2:0]          grant_ch_o,
	output logic [NCH-1:0]      grant_oh_o
);
	logic [NCH-1:0] elig;
	logic [NCH-1:0] next_oh;

	assign elig = pend_i & ~busy_i;

	// fixed priority, lowest channel wins; keeps the arbiter small
	always_comb begin
		next_oh = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (elig[i]) begin
				next_oh = '0;
				next_oh[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			grant_vld_o <= 1'b0;
			grant_ch_o  <= 3'h0;
			grant_oh_o  <= '0;
		end else begin
			grant_vld_o <= take_ok_i && (|next_oh);
			grant_oh_o  <= take_ok_i ? next_oh : '0;
			grant_ch_o  <= 3'h0;
			for (int i = 0; i < NCH; i++) begin
				if (next_oh[i]) begin
					grant_ch_o <= 3'(i);
				end
			end
		end
	end
endmodule

// ===== core/qst_defs.svh
`ifndef QST_DEFS_SVH
`define QST_DEFS_SVH

// register byte offsets
`define QST_OFF_STATUS   12'h000
`define QST_OFF_CLEAR    12'h004
`define QST_OFF_ENABLE   12'h008
`define QST_OFF_EN_SET   12'h00C
`define QST_OFF_EN_CLR   12'h010
`define QST_OFF_LATCH    12'h014

// field layout
`define QST_CH_MSB       7
`define QST_CH_LSB       0

// reset values
`define QST_RST_STATUS   8'h00
`define QST_RST_LATCH    8'h00
`define QST_RST_ENABLE   8'h00

// bus answers
`define QST_RESP_OKAY    2'h0
`define QST_RESP_SLVERR  2'h2

`endif

// ===== core/qst_pkg.sv
package qst_pkg;
	typedef logic [7:0] qst_chan_t;

	typedef struct packed {
		logic        valid;
		logic [2:0]  chan;
	} qst_evt_t;

	typedef struct packed {
		logic [1:0]  resp;
		logic [31:0] data;
	} qst_rd_t;
endpackage

// ===== core/qst_tracker.sv
// Notes on behaviour
// - one status bit per channel, bits 7-0
// - status reads 1 while event queued
// - status reads 0 when nothing queued
// - queued channel is not prioritised again
// - clear write of 1 drops status and latch
// - clear write of 0 changes nothing
// - ordinary clear drops secondary bits only
// - status cleared by hardware or software first
// - disabled channel latches no event
`timescale 1ns/1ns
`include "qst_defs.svh"
module qst_tracker #(
	parameter int NCH = 8
) (
	// clock and reset
	input  wire logic            ref_clk_i,
	input  wire logic            rst_i,
	// axi4-lite write
	input  wire logic [11:0]     s_axi_awaddr,
	input  wire logic            s_axi_awvalid,
	output logic                 s_axi_awready,
	input  wire logic [31:0]     s_axi_wdata,
	input  wire logic [3:0]      s_axi_wstrb,
	input  wire logic            s_axi_wvalid,
	output logic                 s_axi_wready,
	output logic [1:0]           s_axi_bresp,
	output logic                 s_axi_bvalid,
	input  wire logic            s_axi_bready,
	// axi4-lite read
	input  wire logic [11:0]     s_axi_araddr,
	input  wire logic            s_axi_arvalid,
	output logic                 s_axi_arready,
	output logic [31:0]          s_axi_rdata,
	output logic [1:0]           s_axi_rresp,
	output logic                 s_axi_rvalid,
	input  wire logic            s_axi_rready,
	// event side
	input  wire logic [NCH-1:0]  evt_i,
	input  wire logic            queue_ready_i,
	input  wire logic [NCH-1:0]  hw_done_i,
	// ordinary channel secondary clear
	input  wire logic [NCH-1:0]  ord_status_i,
	input  wire logic            ord_clear_i,
	input  wire logic [NCH-1:0]  ord_clear_mask_i,
	// queue submission
	output qst_pkg::qst_evt_t    submit_o,
	output qst_pkg::qst_chan_t   status_o,
	output logic [NCH-1:0]       ord_status_o,
	output logic [NCH-1:0]       latch_o
);
	logic [NCH-1:0] status;
	logic [NCH-1:0] latch;
	logic [NCH-1:0] enable;
	logic [NCH-1:0] ord_status;
	logic [NCH-1:0] grant_oh;
	logic           grant_vld;
	logic [2:0]     grant_ch;
	logic           aw_held;
	logic           w_held;
	logic [11:0]    aw_addr;
	logic [31:0]    w_data;
	logic [3:0]     w_strb;
	logic           wr_go;
	logic [NCH-1:0] wr_ones;
	logic [NCH-1:0] sw_clr;
	logic [NCH-1:0] en_set;
	logic [NCH-1:0] en_clr;
	logic           wr_hit;
	qst_pkg::qst_rd_t next_rd;

	// write channel: address and data accepted in either order
	assign wr_go   = aw_held && w_held && !s_axi_bvalid;
	assign wr_ones = w_strb[0] ? w_data[NCH-1:0] : '0;
	assign sw_clr  = (wr_go && aw_addr == `QST_OFF_CLEAR) ? wr_ones : '0;
	assign en_set  = (wr_go && aw_addr == `QST_OFF_EN_SET) ? wr_ones : '0;
	assign en_clr  = (wr_go && aw_addr == `QST_OFF_EN_CLR) ? wr_ones : '0;
	assign wr_hit  = aw_addr == `QST_OFF_CLEAR || aw_addr == `QST_OFF_EN_SET
		|| aw_addr == `QST_OFF_EN_CLR;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 12'h000;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `QST_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready;
			s_axi_wready  <= !w_held && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[11:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `QST_RESP_OKAY : `QST_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read channel
	always_comb begin
		next_rd.resp = `QST_RESP_OKAY;
		next_rd.data = 32'h00000000;
		case ({s_axi_araddr[11:2], 2'h0})
			`QST_OFF_STATUS: next_rd.data[`QST_CH_MSB:`QST_CH_LSB] = status;
			`QST_OFF_CLEAR:  next_rd.data = 32'h00000000;
			`QST_OFF_ENABLE: next_rd.data[`QST_CH_MSB:`QST_CH_LSB] = enable;
			`QST_OFF_LATCH:  next_rd.data[`QST_CH_MSB:`QST_CH_LSB] = latch;
			default:         next_rd.resp = `QST_RESP_SLVERR;
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `QST_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rd.data;
				s_axi_rresp  <= next_rd.resp;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// event enable
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			enable <= `QST_RST_ENABLE;
		end else begin
			enable <= (enable | en_set) & ~en_clr;
		end
	end

	qst_arbiter #(
		.NCH(NCH)
	) u_arb (
		.ref_clk_i   (ref_clk_i),
		.rst_i       (rst_i),
		.pend_i      (latch),
		.busy_i      (status | grant_oh),
		.take_ok_i   (queue_ready_i),
		.grant_vld_o (grant_vld),
		.grant_ch_o  (grant_ch),
		.grant_oh_o  (grant_oh)
	);

	// per-channel latch and secondary status
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		always_ff @(posedge ref_clk_i or posedge rst_i) begin
			if (rst_i) begin
				latch[c] <= 1'b0;
			end else if (evt_i[c] && enable[c]) begin
				latch[c] <= 1'b1;
			end else if (sw_clr[c] || grant_oh[c]) begin
				latch[c] <= 1'b0;
			end
		end

		// a grant that lands with a clear still sets the bit, so no queued entry goes untracked
		always_ff @(posedge ref_clk_i or posedge rst_i) begin
			if (rst_i) begin
				status[c] <= 1'b0;
			end else if (grant_oh[c]) begin
				status[c] <= 1'b1;
			end else if (sw_clr[c] || hw_done_i[c]) begin
				status[c] <= 1'b0;
			end
		end

		// ordinary clear drops the masked secondary bits; a new ordinary event in the same cycle wins
		always_ff @(posedge ref_clk_i or posedge rst_i) begin
			if (rst_i) begin
				ord_status[c] <= 1'b0;
			end else if (ord_status_i[c]) begin
				ord_status[c] <= 1'b1;
			end else if (ord_clear_i && ord_clear_mask_i[c]) begin
				ord_status[c] <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			submit_o     <= '0;
			status_o     <= `QST_RST_STATUS;
			ord_status_o <= '0;
			latch_o      <= `QST_RST_LATCH;
		end else begin
			submit_o.valid <= grant_vld;
			submit_o.chan  <= grant_ch;
			status_o       <= status;
			ord_status_o   <= ord_status;
			latch_o        <= latch;
		end
	end
endmodule
